/* src/dphs_pkg.sv */
// Constants, commands and carrier types for the semaphore-port host controller.
package dphs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FLAG_COUNT = 8;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned INDEX_W = 3;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned FLAG_BIT = 0;
  localparam logic [INDEX_W-1:0] LAST_INDEX = 3'h7;
  // Least times on the pins; each rounds up to whole clock cycles.
  localparam int unsigned ADDR_SETUP_NS = 10;
  localparam int unsigned WRITE_PULSE_NS = 15;
  localparam int unsigned WRITE_HOLD_NS = 10;
  localparam int unsigned READ_ACCESS_NS = 15;
  localparam int unsigned DESELECT_NS = 10;
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PULSE_CYC =
    CNT_W'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [CNT_W-1:0] GAP_CYC =
    CNT_W'((DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] POLL_MAX = 8'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef enum logic [1:0] {
    DPHS_OP_INIT,
    DPHS_OP_CLAIM,
    DPHS_OP_RELEASE,
    DPHS_OP_PEEK
  } dphs_op_t;

  typedef struct packed {
    dphs_op_t op;
    logic [INDEX_W-1:0] index;
    logic keep_polling;
  } dphs_cmd_t;

  typedef struct packed {
    logic granted;
    logic flag;
    logic spread_ok;
  } dphs_rsp_t;

  typedef struct packed {
    logic flag_space_select_n;
    logic mem_enable_n;
    logic out_enable_n;
    logic write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_o;
    logic data_oe;
  } dphs_pins_t;

  localparam dphs_pins_t PINS_IDLE = '{
    flag_space_select_n: 1'b1, mem_enable_n: 1'b1, out_enable_n: 1'b1,
    write_n: 1'b1, addr: 13'h0000, data_o: 18'h00000, data_oe: 1'b0};
endpackage : dphs_pkg

/* src/dphs_sync.sv */
// Two-stage synchroniser for the data bus coming back from the device.
`timescale 1ns/1ps
module dphs_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic [dphs_pkg::DATA_W-1:0] async_i,
  output logic [dphs_pkg::DATA_W-1:0] sync_o
);
  logic [dphs_pkg::DATA_W-1:0] meta_q;
  logic [dphs_pkg::DATA_W-1:0] sync_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= 18'h00000;
      sync_q <= 18'h00000;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : dphs_sync

/* src/dphs_host.sv */
// Host controller that claims, releases and reads one port's semaphore flags.
// How it works
// - Host selects flag space low and uses address, output and write enables.
// - Host drops select and output enable between every two reads.
// - A claim writes zero then reads back; zero read means granted.
// - A failed claim keeps polling or writes one to withdraw.
// - Initialisation writes one to all eight flags.
// - Host keeps the memory array enable high during flag accesses.
`timescale 1ns/1ps
module dphs_host (
  input wire logic clk,
  input wire logic reset,
  input wire dphs_pkg::dphs_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output logic rsp_valid,
  output dphs_pkg::dphs_rsp_t rsp,
  output logic flags_initialised,
  output dphs_pkg::dphs_pins_t pins,
  input wire logic [dphs_pkg::DATA_W-1:0] data_i
);
  typedef enum logic [2:0] {
    DPHS_S_IDLE,
    DPHS_S_WSETUP,
    DPHS_S_WPULSE,
    DPHS_S_WHOLD,
    DPHS_S_READ,
    DPHS_S_GAP
  } dphs_state_t;

  typedef enum logic [1:0] {
    DPHS_STEP_REQ,
    DPHS_STEP_READ,
    DPHS_STEP_WITHDRAW,
    DPHS_STEP_FREE
  } dphs_step_t;

  dphs_state_t state_q, state_d;
  dphs_step_t step_q, step_d;
  dphs_pkg::dphs_cmd_t cmd_q, cmd_d;
  logic [dphs_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [dphs_pkg::CNT_W-1:0] polls_q, polls_d;
  logic wval_q, wval_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d;
  dphs_pkg::dphs_rsp_t rsp_q, rsp_d;
  logic init_q, init_d;
  dphs_pkg::dphs_pins_t pins_q, pins_d;
  logic [dphs_pkg::DATA_W-1:0] data_s;
  logic last_cnt;

  dphs_sync u_sync (
    .clk(clk),
    .reset(reset),
    .async_i(data_i),
    .sync_o(data_s)
  );

  // A flag read sets spread_ok only when every data bit carries the same value; granted does not depend on it.
  function automatic logic spread_agrees(input logic [dphs_pkg::DATA_W-1:0] w);
    spread_agrees = (w == 18'h00000) || (w == 18'h3FFFF);
  endfunction : spread_agrees

  assign last_cnt = (cnt_q == dphs_pkg::CNT_ONE);

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    polls_d = polls_q;
    wval_d = wval_q;
    ready_d = 1'b0;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    init_d = init_q;
    pins_d = dphs_pkg::PINS_IDLE;
    case (state_q)
      DPHS_S_IDLE: begin
        ready_d = 1'b1;
        if (cmd_valid && ready_q) begin
          ready_d = 1'b0;
          cmd_d = cmd;
          polls_d = 8'h00;
          cnt_d = dphs_pkg::SETUP_CYC;
          state_d = DPHS_S_WSETUP;
          case (cmd.op)
            dphs_pkg::DPHS_OP_INIT: begin
              cmd_d.index = 3'h0;
              step_d = DPHS_STEP_FREE;
              wval_d = 1'b1;
            end
            dphs_pkg::DPHS_OP_CLAIM: begin
              step_d = DPHS_STEP_REQ;
              wval_d = 1'b0; // Write first, never read first.
            end
            dphs_pkg::DPHS_OP_RELEASE: begin
              step_d = DPHS_STEP_FREE;
              wval_d = 1'b1;
            end
            dphs_pkg::DPHS_OP_PEEK: begin
              step_d = DPHS_STEP_READ;
              cnt_d = dphs_pkg::READ_CYC;
              state_d = DPHS_S_READ;
            end
            default: begin
              state_d = DPHS_S_IDLE;
              ready_d = 1'b1;
            end
          endcase
        end
      end
      DPHS_S_WSETUP: begin
        cnt_d = cnt_q - dphs_pkg::CNT_ONE;
        if (last_cnt) begin
          cnt_d = dphs_pkg::PULSE_CYC;
          state_d = DPHS_S_WPULSE;
        end
      end
      DPHS_S_WPULSE: begin
        cnt_d = cnt_q - dphs_pkg::CNT_ONE;
        if (last_cnt) begin
          cnt_d = dphs_pkg::HOLD_CYC;
          state_d = DPHS_S_WHOLD;
        end
      end
      DPHS_S_WHOLD: begin
        cnt_d = cnt_q - dphs_pkg::CNT_ONE;
        if (last_cnt) begin
          cnt_d = dphs_pkg::GAP_CYC;
          state_d = DPHS_S_GAP;
        end
      end
      DPHS_S_READ: begin
        cnt_d = cnt_q - dphs_pkg::CNT_ONE;
        if (last_cnt) begin
          rsp_d.flag = data_s[dphs_pkg::FLAG_BIT];
          rsp_d.spread_ok = spread_agrees(data_s);
          rsp_d.granted = (cmd_q.op == dphs_pkg::DPHS_OP_CLAIM) &&
            !data_s[dphs_pkg::FLAG_BIT];
          polls_d = polls_q + dphs_pkg::CNT_ONE;
          cnt_d = dphs_pkg::GAP_CYC;
          state_d = DPHS_S_GAP; // Deselect so the next read re-latches.
        end
      end
      DPHS_S_GAP: begin
        cnt_d = cnt_q - dphs_pkg::CNT_ONE;
        if (last_cnt) begin
          state_d = DPHS_S_IDLE;
          rsp_valid_d = 1'b1;
          case (step_q)
            DPHS_STEP_REQ: begin
              step_d = DPHS_STEP_READ;
              cnt_d = dphs_pkg::READ_CYC;
              state_d = DPHS_S_READ;
              rsp_valid_d = 1'b0;
            end
            DPHS_STEP_READ: begin
              // A lost claim must not leave a stale zero behind in the device.
              if (cmd_q.op == dphs_pkg::DPHS_OP_CLAIM && rsp_q.flag) begin
                rsp_valid_d = 1'b0;
                if (cmd_q.keep_polling && polls_q < dphs_pkg::POLL_MAX) begin
                  cnt_d = dphs_pkg::READ_CYC;
                  state_d = DPHS_S_READ;
                end else begin
                  step_d = DPHS_STEP_WITHDRAW;
                  wval_d = 1'b1;
                  cnt_d = dphs_pkg::SETUP_CYC;
                  state_d = DPHS_S_WSETUP;
                end
              end
            end
            DPHS_STEP_WITHDRAW: begin
              rsp_d.granted = 1'b0;
            end
            DPHS_STEP_FREE: begin
              rsp_d = '{granted: 1'b0, flag: 1'b1, spread_ok: 1'b1};
              if (cmd_q.op == dphs_pkg::DPHS_OP_INIT) begin
                if (cmd_q.index == dphs_pkg::LAST_INDEX) begin
                  init_d = 1'b1;
                end else begin
                  cmd_d.index = cmd_q.index + 3'h1;
                  cnt_d = dphs_pkg::SETUP_CYC;
                  state_d = DPHS_S_WSETUP;
                  rsp_valid_d = 1'b0;
                end
              end
            end
            default: begin
              rsp_valid_d = 1'b1;
            end
          endcase
        end
      end
      default: begin
        state_d = DPHS_S_IDLE;
      end
    endcase
    // Pins follow the state being entered, so they come straight from flops.
    // The array enable stays high throughout: flags never gate memory traffic.
    if (state_d == DPHS_S_WSETUP || state_d == DPHS_S_WPULSE || state_d == DPHS_S_WHOLD ||
        state_d == DPHS_S_READ) begin
      pins_d.flag_space_select_n = 1'b0;
      pins_d.addr = {10'h000, cmd_d.index};
    end
    if (state_d == DPHS_S_WSETUP || state_d == DPHS_S_WPULSE || state_d == DPHS_S_WHOLD) begin
      pins_d.data_oe = 1'b1;
      pins_d.data_o = {17'h00000, wval_d};
    end
    if (state_d == DPHS_S_WPULSE) begin
      pins_d.write_n = 1'b0;
    end
    if (state_d == DPHS_S_READ) begin
      pins_d.out_enable_n = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= DPHS_S_IDLE;
      step_q <= DPHS_STEP_REQ;
      cmd_q <= '{op: dphs_pkg::DPHS_OP_INIT, index: 3'h0, keep_polling: 1'b0};
      cnt_q <= 8'h00;
      polls_q <= 8'h00;
      wval_q <= 1'b1;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '{granted: 1'b0, flag: 1'b1, spread_ok: 1'b1};
      init_q <= 1'b0;
      pins_q <= dphs_pkg::PINS_IDLE;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      polls_q <= polls_d;
      wval_q <= wval_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      init_q <= init_d;
      pins_q <= pins_d;
    end
  end

  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign flags_initialised = init_q;
  assign pins = pins_q;
endmodule : dphs_host

/* sim/dphs_host_assertions.sv */
// Concurrent checks on the ports of the semaphore host controller.
`timescale 1ns/1ps
module dphs_host_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire dphs_pkg::dphs_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire dphs_pkg::dphs_rsp_t rsp,
  input wire logic flags_initialised,
  input wire dphs_pkg::dphs_pins_t pins,
  input wire logic [dphs_pkg::DATA_W-1:0] data_i
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  mem_idle_a: assert property (pins.mem_enable_n)
    else $error("array enable driven low");
  addr_high_a: assert property (pins.addr[12:3] == 10'h000)
    else $error("upper address lines not zero");
  data_high_a: assert property (pins.data_oe |-> pins.data_o[17:1] == 17'h00000)
    else $error("upper data bits driven nonzero");
  read_quiet_a: assert property (!pins.out_enable_n |-> pins.write_n && !pins.data_oe)
    else $error("bus driven during a read");
  write_hold_a: assert property (
    !pins.write_n |-> !pins.flag_space_select_n && pins.data_oe && $stable(pins.addr))
    else $error("write without stable selected access");
  desel_gap_a: assert property ($fell(pins.out_enable_n) |-> ##4
    pins.out_enable_n && pins.flag_space_select_n)
    else $error("read not closed by a deselect");
  standby_a: assert property (
    cmd_ready |-> pins.flag_space_select_n && pins.out_enable_n && pins.write_n)
    else $error("port not in standby while idle");
  release_time_a: assert property (
    cmd_valid && cmd_ready && cmd.op == dphs_pkg::DPHS_OP_RELEASE
    |-> ##1 !rsp_valid [*5] ##[1:3] rsp_valid)
    else $error("release response out of time");
  grant_zero_a: assert property (rsp_valid && rsp.granted |-> !rsp.flag && rsp.spread_ok)
    else $error("grant without a zero read");
  init_keep_a: assert property (flags_initialised |=> flags_initialised)
    else $error("initialised flag dropped");
endmodule : dphs_host_assertions

bind dphs_host dphs_host_assertions chk (.clk(clk), .reset(reset), .cmd(cmd),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
  .flags_initialised(flags_initialised), .pins(pins), .data_i(data_i));

/* sim/dphs_device.sv */
// Behavioural model of the device's eight semaphore flags, host on the left port.
`timescale 1ns/1ps
module dphs_device (
  input wire dphs_pkg::dphs_pins_t pins,
  input wire logic r_we,
  input wire logic [2:0] r_idx,
  input wire logic r_val,
  input wire logic split,
  output logic [dphs_pkg::DATA_W-1:0] data
);
  // Latches power up unknown; nothing here clears them.
  logic [7:0] req_l;
  logic [7:0] req_r;
  logic [7:0] own_l;
  logic [7:0] own_r;
  logic q;
  logic rd = 1'b0;
  wire logic [2:0] a = pins.addr[2:0];
  always @(posedge pins.write_n) begin
    if (pins.flag_space_select_n === 1'b0 && pins.data_oe === 1'b1) begin
      req_l[a] = pins.data_o[0];
      if (!pins.data_o[0] && own_r[a] !== 1'b1) own_l[a] = 1'b1;
      if (pins.data_o[0]) begin
        own_l[a] = 1'b0;
        if (req_r[a] === 1'b0) own_r[a] = 1'b1;
      end
    end
  end
  always @(posedge r_we) begin
    req_r[r_idx] = r_val;
    if (!r_val && own_l[r_idx] !== 1'b1) own_r[r_idx] = 1'b1;
    if (r_val) begin
      own_r[r_idx] = 1'b0;
      if (req_l[r_idx] === 1'b0) own_l[r_idx] = 1'b1;
    end
  end
  // Latched on entry to a read so a write from the other port cannot disturb it.
  always @(pins) begin
    if (pins.flag_space_select_n || pins.out_enable_n) rd = 1'b0;
    else if (!rd) begin
      q = ~own_l[a];
      rd = 1'b1;
    end
  end
  // A released bus shows the inverse of the last value, so no stale level can pass.
  assign data = (!pins.flag_space_select_n && !pins.out_enable_n) ?
    {dphs_pkg::DATA_W{q}} ^ {split, 17'h00000} : {dphs_pkg::DATA_W{~q}};
endmodule : dphs_device

/* sim/dphs_host_test.sv */
// Self-checking bench for the semaphore host controller against the flag model.
`timescale 1ns/1ps
module dphs_host_test;
  logic clk;
  logic reset;
  dphs_pkg::dphs_cmd_t cmd;
  logic cmd_valid;
  logic cmd_ready;
  logic rsp_valid;
  dphs_pkg::dphs_rsp_t rsp;
  logic flags_initialised;
  dphs_pkg::dphs_pins_t pins;
  logic [dphs_pkg::DATA_W-1:0] data_i;
  logic r_we;
  logic [2:0] r_idx;
  logic r_val;
  logic split;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // Row: other-port action (1 claim, 2 free), op, index, expected {granted, flag}.
  logic [15:0] rows [15] = '{16'h0122, 16'h0320, 16'h0221, 16'h0321, 16'h0172,
    16'h0271, 16'h0301, 16'h1131, 16'h2331, 16'h0142, 16'h1340, 16'h0241,
    16'h0341, 16'h2142, 16'h0241};
  dphs_host uut (.clk(clk), .reset(reset), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .flags_initialised(flags_initialised), .pins(pins), .data_i(data_i));
  dphs_device dev (.pins(pins), .r_we(r_we), .r_idx(r_idx), .r_val(r_val),
    .split(split), .data(data_i));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task summarize;
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task check(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask : check
  task rside(input logic [2:0] i, input logic v);
    @(posedge clk);
    r_idx <= i;
    r_val <= v;
    r_we <= 1'b1;
    @(posedge clk);
    r_we <= 1'b0;
  endtask : rside
  task run(input dphs_pkg::dphs_op_t op, input logic [2:0] i, input logic p);
    int k;
    k = 0;
    @(posedge clk);
    cmd <= '{op: op, index: i, keep_polling: p};
    cmd_valid <= 1'b1;
    #1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (rsp_valid !== 1'b1 && k < 300);
    if (k >= 300) begin
      fails++;
      $display("mismatch at %0t: no response", $time);
    end
  endtask : run
  initial begin
    reset = 1'b1;
    cmd = '0;
    cmd_valid = 1'b0;
    r_we = 1'b0;
    r_idx = 3'h0;
    r_val = 1'b1;
    split = 1'b0;
    @(posedge clk);
    #1;
    check({cmd_ready, flags_initialised, pins.flag_space_select_n}, 3'h1);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rside(3'(i), 1'b1);
    run(dphs_pkg::DPHS_OP_INIT, 3'h0, 1'b0);
    check({flags_initialised, rsp.flag, rsp.spread_ok}, 3'h7);
    foreach (rows[j]) begin
      if (rows[j][15:12] != 4'h0) rside(rows[j][6:4], rows[j][13]);
      run(dphs_pkg::dphs_op_t'(rows[j][9:8]), rows[j][6:4], 1'b0);
      check(rsp, {rows[j][1:0], 1'b1});
    end
    rside(3'h5, 1'b0);
    fork
      run(dphs_pkg::DPHS_OP_CLAIM, 3'h5, 1'b1);
      begin
        repeat (40) @(posedge clk);
        rside(3'h5, 1'b1);
      end
    join
    check(rsp, 3'h5);
    run(dphs_pkg::DPHS_OP_RELEASE, 3'h5, 1'b0);
    check(rsp, 3'h3);
    rside(3'h6, 1'b0);
    run(dphs_pkg::DPHS_OP_CLAIM, 3'h6, 1'b1);
    check(rsp, 3'h3);
    rside(3'h6, 1'b1);
    run(dphs_pkg::DPHS_OP_PEEK, 3'h6, 1'b0);
    check(rsp, 3'h3);
    @(posedge clk);
    split <= 1'b1;
    run(dphs_pkg::DPHS_OP_PEEK, 3'h5, 1'b0);
    check(rsp, 3'h2);
    @(posedge clk);
    split <= 1'b0;
    reset <= 1'b1;
    @(posedge clk);
    #1;
    check({cmd_ready, flags_initialised, pins.flag_space_select_n}, 3'h1);
    @(posedge clk);
    reset <= 1'b0;
    run(dphs_pkg::DPHS_OP_PEEK, 3'h5, 1'b0);
    check({flags_initialised, rsp.flag, rsp.spread_ok}, 3'h3);
    summarize();
  end
endmodule : dphs_host_test
